// ===== mods_pkg.sv
// Package for the motor operation data store
package mods_pkg;
    localparam int NUM_ENTRIES = 8;
    localparam int IDX_W       = 3;
    localparam int ADDR_W      = 8;

    // Register byte addresses
    localparam logic [ADDR_W-1:0] OFS_CTRL     = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_STATUS   = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h0c;
    localparam logic [ADDR_W-1:0] OFS_ACTIVE   = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_ENTRY    = 8'h40;
    localparam logic [ADDR_W-1:0] OFS_ENTRY_END = 8'h80;
    localparam int ENTRY_STRIDE_SH = 3;

    // Entry word 0: speed [11:0], torque [23:16]
    localparam int SPD_LSB = 0;
    localparam int SPD_W   = 12;
    localparam int TRQ_LSB = 16;
    localparam int TRQ_W   = 8;
    // Entry word 1: accel [7:0], decel [15:8], selectors
    localparam int ACC_LSB  = 0;
    localparam int TIME_W   = 8;
    localparam int DEC_LSB  = 8;
    localparam int SSEL_LSB = 16;
    localparam int TSEL_LSB = 20;
    localparam int SEL_W    = 2;

    // Control bits
    localparam int CTRL_RUN_BIT  = 0;
    localparam int CTRL_EXT_BIT  = 1;
    localparam int CTRL_IDX_LSB  = 4;
    // Interrupt bits
    localparam int IRQ_PROHIB_BIT = 0;
    localparam int IRQ_REJECT_BIT = 1;
    localparam int IRQ_W          = 2;

    // Ranges, times in units of 0.1 s, torque in percent of rated
    localparam logic [SPD_W-1:0]  SPD_MIN   = 12'd80;
    localparam logic [SPD_W-1:0]  SPD_MAX   = 12'd3150;
    localparam logic [SPD_W-1:0]  SPD_RST   = 12'd0;
    localparam logic [SPD_W-1:0]  SPD_REF   = 12'd3000;
    localparam logic [TRQ_W-1:0]  TRQ_MAX   = 8'd200;
    localparam logic [TRQ_W-1:0]  TRQ_RST   = 8'd200;
    localparam logic [TRQ_W-1:0]  TRQ_RATED = 8'd100;
    localparam logic [TIME_W-1:0] TIME_MIN  = 8'd1;
    localparam logic [TIME_W-1:0] TIME_MAX  = 8'd150;
    localparam logic [TIME_W-1:0] TIME_RST  = 8'd5;

    typedef enum logic [SEL_W-1:0] {
        MODS_SRC_DIGITAL  = 2'h0,
        MODS_SRC_EXTERNAL = 2'h3
    } mods_src_t;

    typedef struct packed {
        logic [SPD_W-1:0]  speed;
        logic [TRQ_W-1:0]  torque;
        logic [TIME_W-1:0] accel;
        logic [TIME_W-1:0] decel;
        mods_src_t         speed_src;
        mods_src_t         torque_src;
    } mods_entry_t;

    typedef struct packed {
        logic              use_ext_speed;
        logic              use_ext_torque;
        logic [SPD_W-1:0]  speed;
        logic [TRQ_W-1:0]  torque;
        logic [TIME_W-1:0] accel;
        logic [TIME_W-1:0] decel;
    } mods_cmd_t;
endpackage

// ===== mods_store.sv
// Motor operation data store with Avalon-MM register slave
//
// The register addresses and register access over Avalon-MM are this design's own decisions.
`timescale 1ns/100ps
//
// Overview of operation
// - Eight entries 0..7, each speed, torque, accel and decel time.
// - Speed selector per entry: 0 digital, 3 external analog or PWM.
// - Torque selector per entry, same codes, resets to digital.
// - Selector writes take effect only once the motor is stopped.
// - Both selectors external in one entry raises its setting error.
// - Running an entry with setting error is refused, prohibited flagged.
// - Global external source picks analog or PWM, resets to analog.
// - Speed accepts 0 or 80..3150 rpm, resets to 0.
// - Torque limit accepts 0..200 percent, resets to 200.
// - Accel time 0.1..15.0 s, default 0.5 s, standstill to 3000 rpm.
// - Decel time 0.1..15.0 s, default 0.5 s, 3000 rpm to stop.
// - Stored speed and torque applied only when selector is digital.
// - Zero speed is exempt from the lower speed limit.
// - Torque limit is relative to rated torque, 100 percent rated.
// - Active source selection of each entry is readable by host.
module mods_store
    import mods_pkg::*;
(
    input  wire logic              clock,
    input  wire logic              sys_rst,
    input  wire logic [ADDR_W-1:0] avs_address,
    input  wire logic              avs_read,
    input  wire logic              avs_write,
    input  wire logic [31:0]       avs_writedata,
    input  wire logic [3:0]        avs_byteenable,
    output logic [31:0]            avs_readdata,
    output logic                   avs_waitrequest,
    input  wire logic              motor_running,
    output logic                   run_cmd,
    output mods_cmd_t              cmd,
    output logic                   ext_sel_pwm,
    output logic                   irq
);

    ////////////////////////////////////////////////////////////////////
    // Bus handshake: one wait cycle, answer on the second edge
    logic              acc;
    logic              wr_acc;
    logic              all_be;
    logic              in_entry;
    logic [IDX_W-1:0]  eidx;
    logic              eword;

    assign acc      = (avs_read | avs_write) & avs_waitrequest;
    assign wr_acc   = avs_write & ~avs_waitrequest;
    assign all_be   = &avs_byteenable;
    assign in_entry = (avs_address >= OFS_ENTRY) &&
                      (avs_address <  OFS_ENTRY_END);
    assign eidx     = avs_address[ENTRY_STRIDE_SH +: IDX_W];
    assign eword    = avs_address[2];

    // Writes commit at the edge that sees waitrequest low
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            avs_waitrequest <= 1'b1;
        end else begin
            avs_waitrequest <= ~acc;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Entry storage
    mods_entry_t       entry [NUM_ENTRIES];
    mods_src_t         pend_ssel [NUM_ENTRIES];
    mods_src_t         pend_tsel [NUM_ENTRIES];
    logic [NUM_ENTRIES-1:0] set_err;
    logic [NUM_ENTRIES-1:0] reject_hit;

    function automatic logic speed_ok(input logic [SPD_W-1:0] v);
        speed_ok = (v == SPD_RST) ||
                   ((v >= SPD_MIN) && (v <= SPD_MAX));
    endfunction

    function automatic logic time_ok(input logic [TIME_W-1:0] v);
        time_ok = (v >= TIME_MIN) && (v <= TIME_MAX);
    endfunction

    function automatic logic sel_ok(input logic [SEL_W-1:0] v);
        sel_ok = (v == MODS_SRC_DIGITAL) || (v == MODS_SRC_EXTERNAL);
    endfunction

    genvar g;
    generate
        for (g = 0; g < NUM_ENTRIES; g++) begin : g_entry
            logic hit0;
            logic hit1;
            logic [SPD_W-1:0]  w_spd;
            logic [TRQ_W-1:0]  w_trq;
            logic [TIME_W-1:0] w_acc;
            logic [TIME_W-1:0] w_dec;
            logic [SEL_W-1:0]  w_ss;
            logic [SEL_W-1:0]  w_ts;
            logic ok0;
            logic ok1;

            assign hit0  = wr_acc & all_be & in_entry &
                           (eidx == IDX_W'(g)) & ~eword;
            assign hit1  = wr_acc & all_be & in_entry &
                           (eidx == IDX_W'(g)) & eword;
            assign w_spd = avs_writedata[SPD_LSB +: SPD_W];
            assign w_trq = avs_writedata[TRQ_LSB +: TRQ_W];
            assign w_acc = avs_writedata[ACC_LSB +: TIME_W];
            assign w_dec = avs_writedata[DEC_LSB +: TIME_W];
            assign w_ss  = avs_writedata[SSEL_LSB +: SEL_W];
            assign w_ts  = avs_writedata[TSEL_LSB +: SEL_W];
            assign ok0   = speed_ok(w_spd) && (w_trq <= TRQ_MAX);
            assign ok1   = time_ok(w_acc) && time_ok(w_dec) &&
                           sel_ok(w_ss) && sel_ok(w_ts);
            assign reject_hit[g] = (hit0 & ~ok0) | (hit1 & ~ok1);

            // Values on accepted write, selectors follow pending when stopped
            always_ff @(posedge clock) begin
                if (sys_rst) begin
                    entry[g].speed      <= SPD_RST;
                    entry[g].torque     <= TRQ_RST;
                    entry[g].accel      <= TIME_RST;
                    entry[g].decel      <= TIME_RST;
                    entry[g].speed_src  <= MODS_SRC_DIGITAL;
                    entry[g].torque_src <= MODS_SRC_DIGITAL;
                end else begin
                    if (hit0 && ok0) begin
                        entry[g].speed  <= w_spd;
                        entry[g].torque <= w_trq;
                    end else if (hit1 && ok1) begin
                        entry[g].accel  <= w_acc;
                        entry[g].decel  <= w_dec;
                    end
                    if (!motor_running) begin
                        entry[g].speed_src  <= pend_ssel[g];
                        entry[g].torque_src <= pend_tsel[g];
                    end
                end
            end

            // Selectors staged, applied once stopped
            always_ff @(posedge clock) begin
                if (sys_rst) begin
                    pend_ssel[g] <= MODS_SRC_DIGITAL;
                    pend_tsel[g] <= MODS_SRC_DIGITAL;
                end else if (hit1 && ok1) begin
                    pend_ssel[g] <= mods_src_t'(w_ss);
                    pend_tsel[g] <= mods_src_t'(w_ts);
                end
            end

            assign set_err[g] =
                (entry[g].speed_src == MODS_SRC_EXTERNAL) &&
                (entry[g].torque_src == MODS_SRC_EXTERNAL);
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    // Control register: run request, entry index, external source
    logic             run_req;
    logic [IDX_W-1:0] sel_idx;
    logic             ctrl_wr;

    assign ctrl_wr = wr_acc & all_be & (avs_address == OFS_CTRL);

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            run_req     <= 1'b0;
            sel_idx     <= '0;
            ext_sel_pwm <= 1'b0;
        end else if (ctrl_wr) begin
            run_req     <= avs_writedata[CTRL_RUN_BIT];
            sel_idx     <= avs_writedata[CTRL_IDX_LSB +: IDX_W];
            ext_sel_pwm <= avs_writedata[CTRL_EXT_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Command output and run gating
    logic        prohibited;
    mods_entry_t cur;

    assign cur        = entry[sel_idx];
    assign prohibited = run_req & set_err[sel_idx];

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            run_cmd <= 1'b0;
            cmd     <= '0;
        end else begin
            run_cmd            <= run_req & ~set_err[sel_idx];
            cmd.use_ext_speed  <= cur.speed_src == MODS_SRC_EXTERNAL;
            cmd.use_ext_torque <= cur.torque_src == MODS_SRC_EXTERNAL;
            cmd.speed  <= (cur.speed_src == MODS_SRC_DIGITAL) ?
                          cur.speed : '0;
            cmd.torque <= (cur.torque_src == MODS_SRC_DIGITAL) ?
                          cur.torque : '0;
            cmd.accel  <= cur.accel;
            cmd.decel  <= cur.decel;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Interrupt status, mask, level output
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_mask;
    logic [IRQ_W-1:0] irq_ev;
    logic             stat_wr;
    logic             mask_wr;

    assign irq_ev  = {|reject_hit, prohibited};
    assign stat_wr = wr_acc & all_be & (avs_address == OFS_IRQ_STAT);
    assign mask_wr = wr_acc & all_be & (avs_address == OFS_IRQ_MASK);

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            irq_stat <= '0;
        end else begin
            irq_stat <= (irq_stat &
                         ~(stat_wr ? avs_writedata[IRQ_W-1:0] : '0)) |
                        irq_ev;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            irq_mask <= '0;
        end else if (mask_wr) begin
            irq_mask <= avs_writedata[IRQ_W-1:0];
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_stat & irq_mask);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Read data
    logic [31:0]      rd;
    logic [15:0]      active_src;
    mods_entry_t      re;

    always_comb begin
        for (int i = 0; i < NUM_ENTRIES; i++) begin
            active_src[2*i]   = entry[i].speed_src == MODS_SRC_EXTERNAL;
            active_src[2*i+1] = entry[i].torque_src == MODS_SRC_EXTERNAL;
        end
    end

    assign re = entry[eidx];

    always_comb begin
        rd = '0;
        if (avs_address == OFS_CTRL) begin
            rd[CTRL_RUN_BIT] = run_req;
            rd[CTRL_EXT_BIT] = ext_sel_pwm;
            rd[CTRL_IDX_LSB +: IDX_W] = sel_idx;
        end else if (avs_address == OFS_STATUS) begin
            rd[NUM_ENTRIES-1:0] = set_err;
            rd[8]  = prohibited;
            rd[9]  = motor_running;
        end else if (avs_address == OFS_IRQ_STAT) begin
            rd[IRQ_W-1:0] = irq_stat;
        end else if (avs_address == OFS_IRQ_MASK) begin
            rd[IRQ_W-1:0] = irq_mask;
        end else if (avs_address == OFS_ACTIVE) begin
            rd[15:0] = active_src;
        end else if (in_entry && !eword) begin
            rd[SPD_LSB +: SPD_W] = re.speed;
            rd[TRQ_LSB +: TRQ_W] = re.torque;
        end else if (in_entry) begin
            rd[ACC_LSB +: TIME_W] = re.accel;
            rd[DEC_LSB +: TIME_W] = re.decel;
            rd[SSEL_LSB +: SEL_W] = pend_ssel[eidx];
            rd[TSEL_LSB +: SEL_W] = pend_tsel[eidx];
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            avs_readdata <= '0;
        end else if (acc && avs_read) begin
            avs_readdata <= rd;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Checks
    a_prohib_blocks_run: assert property (
        @(posedge clock) disable iff (sys_rst)
        prohibited |=> !run_cmd)
        else $error("run despite setting error");
    a_prohib_sets_irq: assert property (
        @(posedge clock) disable iff (sys_rst)
        prohibited |=> irq_stat[IRQ_PROHIB_BIT])
        else $error("prohibited not flagged");
    a_sel_hold_run: assert property (
        @(posedge clock) disable iff (sys_rst)
        $past(motor_running) && motor_running |-> $stable(active_src))
        else $error("selector changed while running");
    a_speed_range: assert property (
        @(posedge clock) disable iff (sys_rst)
        speed_ok(entry[sel_idx].speed))
        else $error("speed out of range");
    a_torque_range: assert property (
        @(posedge clock) disable iff (sys_rst)
        entry[sel_idx].torque <= TRQ_MAX)
        else $error("torque over");
    a_accel_range: assert property (
        @(posedge clock) disable iff (sys_rst)
        time_ok(entry[sel_idx].accel))
        else $error("accel out");
    a_decel_range: assert property (
        @(posedge clock) disable iff (sys_rst)
        time_ok(entry[sel_idx].decel))
        else $error("decel out");
    a_ext_zero_spd: assert property (
        @(posedge clock) disable iff (sys_rst)
        cmd.use_ext_speed |-> cmd.speed == '0)
        else $error("digital speed used in external mode");
    a_reject_keep: assert property (
        @(posedge clock) disable iff (sys_rst)
        |reject_hit |=> irq_stat[IRQ_REJECT_BIT])
        else $error("reject not flagged");
    a_bus_one_wait: assert property (
        @(posedge clock) disable iff (sys_rst)
        acc |=> !avs_waitrequest ##1 avs_waitrequest)
        else $error("bus answer timing");
    a_ext_zero_trq: assert property (
        @(posedge clock) disable iff (sys_rst)
        cmd.use_ext_torque |-> cmd.torque == '0)
        else $error("digital torque used in external mode");
    a_dig_speed_cmd: assert property (
        @(posedge clock) disable iff (sys_rst)
        cur.speed_src == MODS_SRC_DIGITAL |=> cmd.speed == $past(cur.speed))
        else $error("digital speed not passed on");
    a_ext_speed_flag: assert property (
        @(posedge clock) disable iff (sys_rst)
        cur.speed_src == MODS_SRC_EXTERNAL |=> cmd.use_ext_speed)
        else $error("external speed not flagged");
    a_src_legal: assert property (
        @(posedge clock) disable iff (sys_rst)
        sel_ok(cur.speed_src) && sel_ok(cur.torque_src))
        else $error("illegal source code");
    a_both_ext_stop: assert property (
        @(posedge clock) disable iff (sys_rst)
        cur.speed_src == MODS_SRC_EXTERNAL &&
        cur.torque_src == MODS_SRC_EXTERNAL |=> !run_cmd)
        else $error("run with both sources external");
    a_stop_applies: assert property (
        @(posedge clock) disable iff (sys_rst)
        !motor_running ##1 $stable(sel_idx) |->
        cur.speed_src == $past(pend_ssel[sel_idx]) &&
        cur.torque_src == $past(pend_tsel[sel_idx]))
        else $error("pending selector not applied when stopped");
    a_no_run_idle: assert property (
        @(posedge clock) disable iff (sys_rst)
        !run_req |=> !run_cmd)
        else $error("run without request");
    a_irq_level: assert property (
        @(posedge clock) disable iff (sys_rst)
        irq == $past(|(irq_stat & irq_mask)))
        else $error("interrupt level wrong");
    a_w1c_clears: assert property (
        @(posedge clock) disable iff (sys_rst)
        stat_wr && avs_writedata[IRQ_REJECT_BIT] && !irq_ev[IRQ_REJECT_BIT]
        |=> !irq_stat[IRQ_REJECT_BIT])
        else $error("status bit not cleared");
    a_rd_hold: assert property (
        @(posedge clock) disable iff (sys_rst)
        !(avs_read && avs_waitrequest) |=> $stable(avs_readdata))
        else $error("read data changed without read");

    c_run: cover property (@(posedge clock) disable iff (sys_rst) run_cmd);
    c_wr_running: cover property (@(posedge clock) disable iff (sys_rst)
        motor_running && avs_write && !avs_waitrequest);
    c_prohib: cover property (@(posedge clock) disable iff (sys_rst)
        prohibited);
    c_reject: cover property (@(posedge clock) disable iff (sys_rst)
        |reject_hit);
    c_irq: cover property (@(posedge clock) disable iff (sys_rst) irq);
endmodule

// ===== mods_motor_model.sv
// Motor side model: runs on request, coasts a few cycles after stop
`timescale 1ns/100ps
module mods_motor_model
    import mods_pkg::*;
#(
    parameter int STOP_DLY = 4
)(
    input  wire logic clock,
    input  wire logic sys_rst,
    input  wire logic run_cmd,
    output logic      motor_running
);
    int stop_cnt;

    // Running follows the request, stopping takes a ramp-down time
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            motor_running <= 1'b0;
            stop_cnt      <= 0;
        end else if (run_cmd) begin
            motor_running <= 1'b1;
            stop_cnt      <= STOP_DLY;
        end else if (stop_cnt > 0) begin
            stop_cnt      <= stop_cnt - 1;
        end else begin
            motor_running <= 1'b0;
        end
    end
endmodule

// ===== test_motor_operation_data_store.sv
// Register-level testbench of the motor operation data store
`timescale 1ns/100ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin \
    error_cnt++; $display("unexpected at %0t: got %h exp %h", \
    $time, (a), (e)); end end
module test_motor_operation_data_store
    import mods_pkg::*;
;
    logic              clock = 1'b0;
    logic              sys_rst = 1'b1;
    logic [ADDR_W-1:0] avs_address = '0;
    logic              avs_read = 1'b0;
    logic              avs_write = 1'b0;
    logic [31:0]       avs_writedata = '0;
    logic [3:0]        avs_byteenable = '0;
    logic [31:0]       avs_readdata;
    logic              avs_waitrequest;
    logic              motor_running;
    logic              run_cmd;
    mods_cmd_t         cmd;
    logic              ext_sel_pwm;
    logic              irq;
    logic [31:0]       rd;
    int                error_cnt = 0;
    int                samples_checked = 0;
    int                cyc = 0;
    // Entry 4 write sequence and the readback each should leave
    logic [31:0] rng_a [10] = '{0, 0, 0, 0, 0, 0, 1, 1, 1, 1};
    logic [31:0] rng_w [10] = '{32'h00c8_0050, 32'h00c8_0c4e,
        32'h00c8_0c4f, 32'h00c8_004f, 32'h0000_0000, 32'h00c9_0000,
        32'h0000_9601, 32'h0000_0001, 32'h0000_0197, 32'h0001_0505};
    logic [31:0] rng_e [10] = '{32'h00c8_0050, 32'h00c8_0c4e,
        32'h00c8_0c4e, 32'h00c8_0c4e, 32'h0000_0000, 32'h0000_0000,
        32'h0000_9601, 32'h0000_9601, 32'h0000_9601, 32'h0000_9601};

    always #12.5 clock = ~clock;

    mods_store dut_u (
        .clock           (clock),
        .sys_rst         (sys_rst),
        .avs_address     (avs_address),
        .avs_read        (avs_read),
        .avs_write       (avs_write),
        .avs_writedata   (avs_writedata),
        .avs_byteenable  (avs_byteenable),
        .avs_readdata    (avs_readdata),
        .avs_waitrequest (avs_waitrequest),
        .motor_running   (motor_running),
        .run_cmd         (run_cmd),
        .cmd             (cmd),
        .ext_sel_pwm     (ext_sel_pwm),
        .irq             (irq)
    );

    mods_motor_model #(.STOP_DLY(4)) motor_u (
        .clock         (clock),
        .sys_rst       (sys_rst),
        .run_cmd       (run_cmd),
        .motor_running (motor_running)
    );

    ////////////////////////////////////////////////////////////////////
    task automatic finish_test();
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    always @(posedge clock) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            finish_test();
        end
    end

    // One Avalon transfer, held until waitrequest is seen low
    task automatic bus_xfer(input logic wr, input logic [ADDR_W-1:0] a,
                            input logic [31:0] d, input logic [3:0] be,
                            output logic [31:0] q);
        @(posedge clock);
        avs_address    <= a;
        avs_write      <= wr;
        avs_read       <= !wr;
        avs_writedata  <= d;
        avs_byteenable <= be;
        do @(posedge clock); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus_xfer(1'b1, a, d, 4'hf, q);
    endtask

    task automatic chk_rd(input logic [ADDR_W-1:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus_xfer(1'b0, a, 32'h0, 4'hf, q);
        `CHK(q, e)
    endtask

    function automatic logic [ADDR_W-1:0] ent(input int n, input int w);
        return OFS_ENTRY + ADDR_W'(n * 8 + w * 4);
    endfunction

    task automatic idle(input int n);
        repeat (n) @(posedge clock);
    endtask

    ////////////////////////////////////////////////////////////////////
    initial begin
        idle(10);
        sys_rst <= 1'b0;
        idle(3);
        `CHK(cmd.speed, SPD_RST)
        `CHK(cmd.torque, TRQ_RST)
        `CHK({cmd.accel, cmd.decel}, {TIME_RST, TIME_RST})
        `CHK({run_cmd, irq, ext_sel_pwm}, 3'h0)
        for (int i = 0; i < NUM_ENTRIES; i++) begin
            chk_rd(ent(i, 0), 32'h00c8_0000);
            chk_rd(ent(i, 1), 32'h0000_0505);
        end
        chk_rd(OFS_CTRL, 32'h0);
        chk_rd(OFS_ACTIVE, 32'h0);
        chk_rd(8'h20, 32'h0);
        // Range limits, zero speed exemption, rejected words
        for (int i = 0; i < 10; i++) begin
            wr(ent(4, rng_a[i]), rng_w[i]);
            chk_rd(ent(4, rng_a[i]), rng_e[i]);
        end
        chk_rd(OFS_IRQ_STAT, 32'h2);
        wr(OFS_IRQ_STAT, 32'h2);
        chk_rd(OFS_IRQ_STAT, 32'h0);
        bus_xfer(1'b1, ent(4, 0), 32'h0000_0064, 4'h3, rd);
        chk_rd(ent(4, 0), 32'h0);
        // Digital values reach the motor side
        wr(ent(1, 0), 32'h0064_05dc);
        wr(ent(1, 1), 32'h0000_0196);
        wr(OFS_CTRL, 32'h11);
        idle(3);
        `CHK(run_cmd, 1'b1)
        `CHK(cmd.speed, 12'd1500)
        `CHK(cmd.torque, TRQ_RATED)
        `CHK({cmd.accel, cmd.decel}, {8'd150, 8'd1})
        `CHK({cmd.use_ext_speed, cmd.use_ext_torque}, 2'b00)
        // Selector change while running stays pending
        wr(ent(2, 1), 32'h0003_0505);
        chk_rd(ent(2, 1), 32'h0003_0505);
        chk_rd(OFS_ACTIVE, 32'h0);
        wr(OFS_CTRL, 32'h0);
        idle(10);
        chk_rd(OFS_ACTIVE, 32'h10);
        wr(OFS_CTRL, 32'h21);
        idle(3);
        `CHK(cmd.use_ext_speed, 1'b1)
        `CHK(cmd.speed, 12'd0)
        `CHK(cmd.torque, TRQ_RST)
        wr(OFS_CTRL, 32'h0);
        idle(10);
        // Both selectors external: setting error, run refused
        wr(ent(3, 1), 32'h0033_0505);
        idle(2);
        bus_xfer(1'b0, OFS_STATUS, 32'h0, 4'hf, rd);
        `CHK(rd[7:0], 8'h08)
        wr(OFS_CTRL, 32'h31);
        idle(3);
        `CHK({run_cmd, motor_running}, 2'b00)
        `CHK({cmd.use_ext_speed, cmd.use_ext_torque, cmd.torque}, 10'h300)
        bus_xfer(1'b0, OFS_STATUS, 32'h0, 4'hf, rd);
        `CHK(rd[8], 1'b1)
        chk_rd(OFS_IRQ_STAT, 32'h1);
        `CHK(irq, 1'b0)
        wr(OFS_IRQ_MASK, 32'h1);
        idle(3);
        `CHK(irq, 1'b1)
        wr(OFS_CTRL, 32'h0);
        wr(OFS_IRQ_STAT, 32'h1);
        idle(3);
        `CHK(irq, 1'b0)
        // Global external source to PWM
        wr(OFS_CTRL, 32'h2);
        idle(3);
        `CHK(ext_sel_pwm, 1'b1)
        chk_rd(OFS_CTRL, 32'h2);
        finish_test();
    end
endmodule
